// ---- include/mps_pkg.sv ----
// constants, encodings and carrier types of the motion program sequencer
// Overview of operation
// - input test reads port 1-12 or flag
// - level code 0 low, 1 high; idle high
// - third operand 0 stalls until level seen
// - third operand 1-99 branches when level present
// - output targets port 1-10 or flag bit
// - output drives low for 0, high for 1
// - sync outputs return high while paused
// - loop target line lower than loop line
// - loop repeats count times, then falls through
// - numeric operands immediate or data register
// - jump goes unconditionally to line 1-99
// - arithmetic codes add, sub, copy, mul, div
// - arithmetic first operand is source and destination
// - compare register against register or immediate
// - compare codes greater, less, equal, signed
// - compare true skips to N+2, else N+1
// - set origin zeroes one axis or all
// - homing moves axis until limit switch closes
// - homing switch port 1-12, 0 goes to zero
// - homing direction 0 reverse, 1 forward
package mps_pkg;
	localparam int CLK_PERIOD_NS = 8;
	localparam int MS_NS         = 1000000;
	localparam int MS_CYCLES_DOC = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int NUM_IN        = 12;
	localparam int NUM_OUT       = 10;
	localparam int NUM_FLAGS     = 100;
	localparam int NUM_DREGS     = 20;
	localparam int NUM_AXES      = 4;
	localparam int MAX_LINE      = 99;
	localparam int FRAC_BITS     = 8;
	localparam int ADDR_W        = 12;
	// ****************************************
	// register map, byte addresses
	// ****************************************
	localparam logic [11:0] ADDR_CTRL    = 12'h000;
	localparam logic [11:0] ADDR_STATUS  = 12'h004;
	localparam logic [11:0] ADDR_INPINS  = 12'h008;
	localparam logic [11:0] ADDR_OUTPINS = 12'h00c;
	localparam logic [11:0] ADDR_FLAGS   = 12'h010;
	localparam logic [11:0] ADDR_HOMEDIV = 12'h020;
	localparam logic [11:0] ADDR_DREG    = 12'h040;
	localparam logic [11:0] ADDR_POS     = 12'h0c0;
	localparam logic [11:0] ADDR_PROG    = 12'h400;
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_PAUSE_BIT = 1;
	localparam int CTRL_ABORT_BIT = 2;
	localparam logic [15:0] HOMEDIV_RESET = 16'h04e2;
	// ****************************************
	// instruction encodings
	// ****************************************
	localparam logic [3:0] OP_HALT   = 4'h0;
	localparam logic [3:0] OP_INPUT  = 4'h1;
	localparam logic [3:0] OP_OUTPUT = 4'h2;
	localparam logic [3:0] OP_DELAY  = 4'h3;
	localparam logic [3:0] OP_LOOP   = 4'h4;
	localparam logic [3:0] OP_JUMP   = 4'h5;
	localparam logic [3:0] OP_ARITH  = 4'h6;
	localparam logic [3:0] OP_CMP    = 4'h7;
	localparam logic [3:0] OP_SETORG = 4'h8;
	localparam logic [3:0] OP_HOME   = 4'h9;
	localparam logic [7:0] AR_ADD = 8'h01;
	localparam logic [7:0] AR_SUB = 8'h02;
	localparam logic [7:0] AR_CPY = 8'h03;
	localparam logic [7:0] AR_MUL = 8'h04;
	localparam logic [7:0] AR_DIV = 8'h05;
	localparam logic [7:0] CMP_GT = 8'h01;
	localparam logic [7:0] CMP_LT = 8'h02;
	localparam logic [7:0] CMP_EQ = 8'h03;
	localparam logic [31:0] AXIS_ALL = 32'h5;
	// first word of a program line; the second word is operand 1
	typedef struct packed {
		logic [3:0]  op;
		logic        p1Reg;
		logic        p2Reg;
		logic        p1Flag;
		logic [7:0]  p3;
		logic [16:0] p2;
	} mps_line_t;
	typedef enum logic [1:0] {S_IDLE, S_RUN, S_DELAY, S_HOME} mps_state_t;
endpackage

// ---- src/mps_sequencer.sv ----
// program-line sequencer with AHB-Lite register access and homing pulse generator
//
// The implementer's own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
module mps_sequencer
	import mps_pkg::*;
#(
	parameter int MS_CYCLES = MS_CYCLES_DOC
)(
	input  wire logic        clock,
	input  wire logic        rst_b,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic [11:0] inPins,
	output logic      [9:0]  outPins,
	output logic      [3:0]  stepOut,
	output logic      [3:0]  dirOut,
	output logic             running
);
	localparam int MSW = $clog2(MS_CYCLES + 1);
	// a zero-length millisecond would never tick the delay counter
	if (MS_CYCLES < 1)
	begin : g_badMsCycles
		$error("MS_CYCLES must be at least one");
	end

	// ****************************************
	// storage
	// ****************************************
	logic        [31:0] progA     [1:MAX_LINE];
	logic        [31:0] progB     [1:MAX_LINE];
	logic        [16:0] loopCnt_q [1:MAX_LINE];
	logic signed [31:0] dreg_q    [0:NUM_DREGS-1];
	logic signed [31:0] pos_q     [0:NUM_AXES-1];
	logic [NUM_FLAGS-1:0] flags_q;
	logic [11:0]  inSync1_q, inSync2_q;
	logic [9:0]   outLevel_q, outSync_q, outPins_q;
	logic [3:0]   stepOut_q, dirOut_q;
	logic [6:0]   pc_q, pcD;
	mps_state_t   state_q, stateD;
	logic         pause_q, running_q;
	logic [19:0]  delayMs_q;
	logic [MSW-1:0] msCnt_q;
	logic [1:0]   homeAxis_q;
	logic [3:0]   homeSw_q;
	logic         homeDir_q;
	logic [15:0]  stepCnt_q, homeDiv_q;
	logic [11:0]  dAddr_q;
	logic         dWrite_q, dValid_q, hreadyout_q;
	logic [31:0]  hrdata_q, rdMux;

	// ****************************************
	// AHB-Lite slave: one wait state per transfer
	// ****************************************
	wire addrPhase = hsel & htrans[1] & hready;
	wire busWr     = dValid_q & dWrite_q;
	wire isCtrl    = dAddr_q == ADDR_CTRL;
	wire isFlag    = dAddr_q[11:4] == ADDR_FLAGS[11:4];
	wire isDreg    = dAddr_q >= ADDR_DREG && dAddr_q < ADDR_DREG + 12'(4 * NUM_DREGS);
	wire isPos     = dAddr_q >= ADDR_POS && dAddr_q < ADDR_POS + 12'(4 * NUM_AXES);
	wire [6:0] progLine = dAddr_q[9:3];
	wire isProg    = dAddr_q[11:10] == ADDR_PROG[11:10] && progLine >= 7'd1
		&& progLine <= 7'(MAX_LINE);
	wire [11:0] dregOff = dAddr_q - ADDR_DREG;
	wire [11:0] posOff  = dAddr_q - ADDR_POS;
	wire [4:0]  dregWIdx = dregOff[6:2];
	wire [1:0]  posWIdx  = posOff[3:2];
	wire startReq = busWr & isCtrl & hwdata[CTRL_START_BIT];
	wire abortReq = busWr & isCtrl & hwdata[CTRL_ABORT_BIT];

	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			dValid_q    <= 1'b0;
			dWrite_q    <= 1'b0;
			dAddr_q     <= 12'h000;
			hreadyout_q <= 1'b1;
			hrdata_q    <= 32'h0000_0000;
		end
		else
		begin
			dValid_q    <= addrPhase;
			hreadyout_q <= !addrPhase;
			if (addrPhase)
			begin
				dAddr_q  <= haddr[ADDR_W-1:0];
				dWrite_q <= hwrite;
			end
			if (dValid_q)
				hrdata_q <= dWrite_q ? 32'h0000_0000 : rdMux;
		end
	end

	always_comb
	begin
		rdMux = 32'h0000_0000;
		if (isCtrl)
			rdMux[CTRL_PAUSE_BIT] = pause_q;
		else if (dAddr_q == ADDR_STATUS)
			rdMux = {20'h00000, 1'b0, pause_q, state_q, 1'b0, pc_q};
		else if (dAddr_q == ADDR_INPINS)
			rdMux[NUM_IN-1:0] = inSync2_q;
		else if (dAddr_q == ADDR_OUTPINS)
			rdMux[NUM_OUT-1:0] = outPins_q;
		else if (isFlag)
		begin
			for (int b = 0; b < 32; b++)
				if (32 * int'(dAddr_q[3:2]) + b < NUM_FLAGS)
					rdMux[b] = flags_q[32 * int'(dAddr_q[3:2]) + b];
		end
		else if (dAddr_q == ADDR_HOMEDIV)
			rdMux[15:0] = homeDiv_q;
		else if (isDreg)
			rdMux = dreg_q[dregWIdx];
		else if (isPos)
			rdMux = pos_q[posWIdx];
		else if (isProg)
			rdMux = dAddr_q[2] ? progB[progLine] : progA[progLine];
	end

	// program memory has no reset; software loads it before a start
	always_ff @(posedge clock)
	begin
		if (busWr && isProg && !dAddr_q[2])
			progA[progLine] <= hwdata;
		if (busWr && isProg && dAddr_q[2])
			progB[progLine] <= hwdata;
	end

	// ****************************************
	// line decode and operand fetch
	// ****************************************
	wire pcOk = pc_q >= 7'd1 && pc_q <= 7'(MAX_LINE);
	wire [6:0] lineIdx = pcOk ? pc_q : 7'd1;
	mps_line_t ln;
	assign ln = progA[lineIdx];
	wire [31:0] p1w = progB[lineIdx];
	wire [31:0] p2w = {15'h0000, ln.p2};
	wire [6:0] pcNext1 = pc_q + 7'd1;
	wire [6:0] pcNext2 = pc_q + 7'd2;
	wire paused = pause_q && state_q != S_IDLE;
	wire exec = state_q == S_RUN && !pause_q && pcOk && !startReq && !abortReq;

	wire signed [31:0] p1Dreg = (p1w < NUM_DREGS) ? dreg_q[p1w[4:0]] : 32'sh0;
	wire signed [31:0] p2Dreg = (p2w < NUM_DREGS) ? dreg_q[p2w[4:0]] : 32'sh0;
	// both arms signed, else the arithmetic shift of a negative register turns logical
	wire signed [31:0] p1Int  = ln.p1Reg ? (p1Dreg >>> FRAC_BITS) : $signed(p1w);
	wire signed [31:0] p2Int  = ln.p2Reg ? (p2Dreg >>> FRAC_BITS) : $signed(p2w);
	wire signed [31:0] bVal   = ln.p2Reg ? p2Dreg
		: {p2w[31-FRAC_BITS:0], {FRAC_BITS{1'b0}}};
	wire signed [31:0] aVal   = p1Dreg;
	wire destOk = p1w < NUM_DREGS;

	// input test operand: ports and flags count from one
	wire [6:0] selIdx = p1w[6:0] - 7'd1;
	wire inRangeIn  = ln.p1Flag ? (p1w >= 1 && p1w <= NUM_FLAGS) : (p1w >= 1 && p1w <= NUM_IN);
	wire inRangeOut = ln.p1Flag ? (p1w >= 1 && p1w <= NUM_FLAGS) : (p1w >= 1 && p1w <= NUM_OUT);
	// an unselectable operand reads as the idle high level
	wire selBit = !inRangeIn ? 1'b1
		: ln.p1Flag ? flags_q[selIdx] : inSync2_q[selIdx[3:0]];
	wire inHit = selBit == ln.p2[0];
	wire [6:0] inTarget = ln.p3[6:0];
	wire inBranchOk = ln.p3 >= 8'd1 && ln.p3 <= 8'(MAX_LINE);

	// loop: count keeps its low 17 bits; a negative count is zero
	wire [6:0]  loopTarget = p1Int[6:0];
	wire [16:0] loopLimit  = (p2Int < 0) ? 17'h00000 : p2Int[16:0];
	wire loopTake = p1Int >= 1 && p1Int < 32'(pc_q)
		&& loopCnt_q[lineIdx] < loopLimit;
	wire jumpOk = p1Int >= 1 && p1Int <= MAX_LINE;

	// ****************************************
	// signed fixed-point arithmetic and compare
	// ****************************************
	wire signed [63:0] prod   = aVal * bVal;
	wire signed [39:0] divNum = $signed({aVal, {FRAC_BITS{1'b0}}});
	wire signed [39:0] divDen = $signed({{FRAC_BITS{bVal[31]}}, bVal});
	wire signed [39:0] quot   = (bVal == 0) ? divNum : divNum / divDen;
	logic signed [31:0] arithRes;
	always_comb
	begin
		arithRes = aVal;
		case (ln.p3)
			AR_ADD: arithRes = aVal + bVal;
			AR_SUB: arithRes = aVal - bVal;
			AR_CPY: arithRes = bVal;
			AR_MUL: arithRes = prod[FRAC_BITS+31:FRAC_BITS];
			// divide by zero leaves the register untouched
			AR_DIV: arithRes = (bVal == 0) ? aVal : quot[31:0];
			default: arithRes = aVal;
		endcase
	end
	wire cmpTrue = (ln.p3 == CMP_GT && aVal > bVal) || (ln.p3 == CMP_LT && aVal < bVal)
		|| (ln.p3 == CMP_EQ && aVal == bVal);

	// ****************************************
	// homing
	// ****************************************
	wire [1:0] axSel = p1w[1:0] - 2'd1;
	wire axisOk = p1w >= 1 && p1w <= NUM_AXES;
	wire homeOk = axisOk && p2Int >= 0 && p2Int <= NUM_IN;
	wire homeDirNew = (p2Int == 0) ? pos_q[axSel][31] : ln.p3[0];
	wire [3:0] swIdx = homeSw_q - 4'd1;
	wire homeDone = (homeSw_q != 4'd0) ? !inSync2_q[swIdx]
		: pos_q[homeAxis_q] == 32'sh0;
	wire stepTick = state_q == S_HOME && !pause_q && !homeDone && stepCnt_q >= homeDiv_q;
	wire delayDone = delayMs_q == 20'h00000;
	wire msTick = msCnt_q == MSW'(MS_CYCLES - 1);

	// ****************************************
	// next line and state
	// ****************************************
	always_comb
	begin
		pcD    = pc_q;
		stateD = state_q;
		if (startReq)
		begin
			pcD    = 7'd1;
			stateD = S_RUN;
		end
		else if (abortReq)
			stateD = S_IDLE;
		else if (!pause_q)
		begin
			case (state_q)
				S_RUN:
					if (!pcOk)
						stateD = S_IDLE;
					else
						case (ln.op)
							OP_INPUT:
								if (ln.p3 == 8'd0)
								begin
									if (inHit)
										pcD = pcNext1;
								end
								else
									pcD = (inHit && inBranchOk) ? inTarget : pcNext1;
							OP_DELAY: stateD = S_DELAY;
							OP_LOOP: pcD = loopTake ? loopTarget : pcNext1;
							OP_JUMP: pcD = jumpOk ? p1Int[6:0] : pcNext1;
							OP_CMP: pcD = cmpTrue ? pcNext2 : pcNext1;
							OP_HOME:
								if (homeOk)
									stateD = S_HOME;
								else
									pcD = pcNext1;
							OP_OUTPUT, OP_ARITH, OP_SETORG: pcD = pcNext1;
							default: stateD = S_IDLE;
						endcase
				S_DELAY:
					if (delayDone)
					begin
						stateD = S_RUN;
						pcD    = pcNext1;
					end
				S_HOME:
					if (homeDone)
					begin
						stateD = S_RUN;
						pcD    = pcNext1;
					end
				default: stateD = S_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			state_q   <= S_IDLE;
			pc_q      <= 7'd1;
			running_q <= 1'b0;
		end
		else
		begin
			state_q   <= stateD;
			pc_q      <= pcD;
			running_q <= stateD != S_IDLE;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			pause_q   <= 1'b0;
			homeDiv_q <= HOMEDIV_RESET;
			inSync1_q <= 12'hfff;
			inSync2_q <= 12'hfff;
			delayMs_q <= 20'h00000;
			msCnt_q   <= '0;
		end
		else
		begin
			inSync1_q <= inPins;
			inSync2_q <= inSync1_q;
			if (busWr && isCtrl)
				pause_q <= hwdata[CTRL_PAUSE_BIT];
			if (busWr && dAddr_q == ADDR_HOMEDIV)
				homeDiv_q <= hwdata[15:0];
			if (exec && ln.op == OP_DELAY)
			begin
				delayMs_q <= p1Int[31] ? 20'h00000 : p1Int[19:0];
				msCnt_q   <= '0;
			end
			else if (state_q == S_DELAY && !pause_q && !delayDone)
			begin
				msCnt_q <= msTick ? '0 : msCnt_q + MSW'(1);
				if (msTick)
					delayMs_q <= delayMs_q - 20'h00001;
			end
		end
	end

	// loop counters restart from zero once their loop falls through
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			for (int i = 1; i <= MAX_LINE; i++)
				loopCnt_q[i] <= 17'h00000;
		end
		else if (exec && ln.op == OP_LOOP)
			loopCnt_q[lineIdx] <= loopTake ? loopCnt_q[lineIdx] + 17'h00001 : 17'h00000;
	end

	// ****************************************
	// data registers and flags: sequencer wins over a bus write in the same cycle
	// ****************************************
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			for (int i = 0; i < NUM_DREGS; i++)
				dreg_q[i] <= 32'sh0;
			flags_q <= {NUM_FLAGS{1'b1}};
		end
		else
		begin
			if (busWr && isDreg)
				dreg_q[dregWIdx] <= hwdata;
			if (busWr && isFlag)
				for (int b = 0; b < 32; b++)
					if (32 * int'(dAddr_q[3:2]) + b < NUM_FLAGS)
						flags_q[32 * int'(dAddr_q[3:2]) + b] <= hwdata[b];
			if (exec && ln.op == OP_ARITH && destOk)
				dreg_q[p1w[4:0]] <= arithRes;
			if (exec && ln.op == OP_OUTPUT && ln.p1Flag && inRangeOut)
				flags_q[selIdx] <= ln.p2[0];
		end
	end

	// ****************************************
	// output ports
	// ****************************************
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			outLevel_q <= 10'h3ff;
			outSync_q  <= 10'h000;
			outPins_q  <= 10'h3ff;
		end
		else
		begin
			if (exec && ln.op == OP_OUTPUT && !ln.p1Flag && inRangeOut)
			begin
				outLevel_q[selIdx[3:0]] <= ln.p2[0];
				outSync_q[selIdx[3:0]]  <= ln.p3[0];
			end
			outPins_q <= outLevel_q | (outSync_q & {NUM_OUT{paused}});
		end
	end

	// ****************************************
	// axis positions and step pulses
	// ****************************************
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			for (int a = 0; a < NUM_AXES; a++)
				pos_q[a] <= 32'sh0;
			homeAxis_q <= 2'd0;
			homeSw_q   <= 4'd0;
			homeDir_q  <= 1'b0;
			stepCnt_q  <= 16'h0000;
			stepOut_q  <= 4'h0;
			dirOut_q   <= 4'h0;
		end
		else
		begin
			stepOut_q <= 4'h0;
			if (exec && ln.op == OP_SETORG)
			begin
				for (int a = 0; a < NUM_AXES; a++)
					if (p1w == AXIS_ALL || (axisOk && 2'(a) == axSel))
						pos_q[a] <= 32'sh0;
			end
			else if (exec && ln.op == OP_HOME && homeOk)
			begin
				homeAxis_q       <= axSel;
				homeSw_q         <= p2Int[3:0];
				homeDir_q        <= homeDirNew;
				dirOut_q[axSel]  <= homeDirNew;
				stepCnt_q        <= 16'h0000;
			end
			else if (state_q == S_HOME && !pause_q)
			begin
				if (homeDone && homeSw_q != 4'd0)
					pos_q[homeAxis_q] <= 32'sh0;
				else if (stepTick)
				begin
					stepCnt_q             <= 16'h0000;
					stepOut_q[homeAxis_q] <= 1'b1;
					pos_q[homeAxis_q]     <= homeDir_q ? pos_q[homeAxis_q] + 32'sd1
						: pos_q[homeAxis_q] - 32'sd1;
				end
				else if (!homeDone)
					stepCnt_q <= stepCnt_q + 16'h0001;
			end
		end
	end

	assign hrdata    = hrdata_q;
	assign hreadyout = hreadyout_q;
	assign hresp     = 1'b0;
	assign outPins   = outPins_q;
	assign stepOut   = stepOut_q;
	assign dirOut    = dirOut_q;
	assign running   = running_q;

	// ****************************************
	// checks
	// ****************************************
	a_input_stall: assert property (@(posedge clock) disable iff (!rst_b)
		exec && ln.op == OP_INPUT && ln.p3 == 8'd0 && !inHit |=> pc_q == $past(pc_q))
		else $error("input wait advanced without the level");
	a_input_branch: assert property (@(posedge clock) disable iff (!rst_b)
		exec && ln.op == OP_INPUT && inBranchOk
		|=> pc_q == ($past(inHit) ? $past(inTarget) : $past(pcNext1)))
		else $error("input branch went to the wrong line");
	a_out_drive: assert property (@(posedge clock) disable iff (!rst_b)
		exec && ln.op == OP_OUTPUT && !ln.p1Flag && inRangeOut ##1 !paused ##1 !paused
		|-> outPins_q[$past(selIdx[3:0], 2)] == $past(ln.p2[0], 2))
		else $error("output port not at commanded level");
	a_pause_high: assert property (@(posedge clock) disable iff (!rst_b)
		paused |=> &(outPins_q | ~$past(outSync_q)))
		else $error("synchronised output low during pause");
	a_loop_back: assert property (@(posedge clock) disable iff (!rst_b)
		exec && ln.op == OP_LOOP |=> pc_q < $past(pc_q) || pc_q == $past(pcNext1))
		else $error("loop moved forward past the next line");
	a_jump_line: assert property (@(posedge clock) disable iff (!rst_b)
		exec && ln.op == OP_JUMP && jumpOk |=> pc_q == $past(p1Int[6:0]))
		else $error("jump missed its target");
	a_arith_add: assert property (@(posedge clock) disable iff (!rst_b)
		exec && ln.op == OP_ARITH && ln.p3 == AR_ADD && destOk
		|=> dreg_q[$past(p1w[4:0])] == $past(aVal) + $past(bVal))
		else $error("add result wrong");
	a_cmp_skip: assert property (@(posedge clock) disable iff (!rst_b)
		exec && ln.op == OP_CMP |=> pc_q == $past(pc_q) + ($past(cmpTrue) ? 7'd2 : 7'd1))
		else $error("compare continued at the wrong line");
	a_origin_all: assert property (@(posedge clock) disable iff (!rst_b)
		exec && ln.op == OP_SETORG && p1w == AXIS_ALL
		|=> pos_q[0] == 0 && pos_q[1] == 0 && pos_q[2] == 0 && pos_q[3] == 0)
		else $error("set origin left an axis nonzero");
	a_home_stop: assert property (@(posedge clock) disable iff (!rst_b)
		state_q == S_HOME && homeDone && !pause_q |=> state_q == S_RUN && stepOut_q == 4'h0)
		else $error("homing kept stepping after the switch closed");
endmodule // mps_sequencer

// ---- testbench/mps_port_model.sv ----
// port-side model: push-buttons and one limit switch per axis on the input ports
`timescale 1ns/1ps
module mps_port_model
#(
	parameter int LIMIT = 5
)(
	input  wire logic        clock,
	input  wire logic        rst_b,
	input  wire logic [3:0]  stepOut,
	input  wire logic [3:0]  dirOut,
	input  wire logic [7:0]  pressed,
	output logic      [11:0] inPins
);
	int         netSteps [4];
	logic [3:0] limitHit;
	// the carriage position is tracked from the steps the device actually issued
	always_ff @(posedge clock)
	begin
		for (int a = 0; a < 4; a++)
		begin
			if (!rst_b)
				netSteps[a] <= 0;
			else if (stepOut[a])
				netSteps[a] <= dirOut[a] ? netSteps[a] + 1 : netSteps[a] - 1;
		end
	end
	// axis a closes its switch on port 9+a once it has travelled LIMIT steps either way
	always_comb
	begin
		for (int a = 0; a < 4; a++)
			limitHit[a] = (netSteps[a] >= LIMIT) || (netSteps[a] <= -LIMIT);
	end
	// contacts pull to ground; an open contact reads high
	assign inPins = ~{limitHit, pressed};
endmodule // mps_port_model

// ---- testbench/test_motion_program_sequencer.sv ----
// self-checking bench of the motion program sequencer
`timescale 1ns/1ps
module test_motion_program_sequencer;
	import mps_pkg::*;
	localparam int MS = 10;
	logic        clock;
	logic        rst_b;
	logic        hsel;
	logic        hwrite;
	logic [1:0]  htrans;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic        hreadyout;
	logic        hresp;
	logic        running;
	logic [11:0] inPins;
	logic [9:0]  outPins;
	logic [3:0]  stepOut;
	logic [3:0]  dirOut;
	logic [7:0]  pressed;
	int          failures;
	int          check_count;
	int          cycles;
	mps_sequencer #(.MS_CYCLES(MS)) dut_u (.clock(clock), .rst_b(rst_b), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.inPins(inPins), .outPins(outPins), .stepOut(stepOut), .dirOut(dirOut),
		.running(running));
	mps_port_model port_u (.clock(clock), .rst_b(rst_b), .stepOut(stepOut),
		.dirOut(dirOut), .pressed(pressed), .inPins(inPins));
	// ****
	// bus and bookkeeping
	// ****
	initial
	begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	always @(posedge clock)
	begin
		cycles = cycles + 1;
		if (cycles == 60000)
		begin
			failures++;
			results();
		end
	end
	task automatic results();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp)
		begin
			failures++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask
	// entered just after a rising edge; holds each phase until hready is seen high
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge clock); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clock); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic put(input int n, input logic [3:0] op, input logic p2r, input logic p1f,
		input logic [7:0] p3, input logic [16:0] p2, input logic [31:0] p1);
		mps_line_t w;
		w = '{op, 1'b0, p2r, p1f, p3, p2};
		bus(1'b1, 32'(ADDR_PROG) + 32'(8 * n), 32'(w));
		bus(1'b1, 32'(ADDR_PROG) + 32'(8 * n + 4), p1);
	endtask
	task automatic do_reset();
		rst_b <= 1'b0;
		pressed <= 8'h0;
		repeat (20) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
	endtask
	task automatic start();
		bus(1'b1, 32'(ADDR_CTRL), 32'h1);
		repeat (4) @(posedge clock);
	endtask
	task automatic run();
		start();
		for (int i = 0; i < 2000 && running === 1'b1; i++)
			@(posedge clock);
	endtask
	// ****
	// scenarios
	// ****
	task automatic t_out();
		do_reset();
		chk("outPins after reset", 32'h3ff, 32'(outPins));
		put(1, OP_OUTPUT, 0, 0, 8'h1, 17'h0, 3);
		put(2, OP_OUTPUT, 0, 0, 8'h0, 17'h0, 5);
		put(3, OP_OUTPUT, 0, 1, 8'h0, 17'h0, 7);
		put(4, OP_JUMP, 0, 0, 8'h0, 17'h0, 4);
		start();
		chk("outPins running", 32'h3eb, 32'(outPins));
		bus(1'b0, 32'(ADDR_FLAGS), 32'h0);
		chk("flag word", 32'hffffffbf, rd);
		bus(1'b1, 32'(ADDR_CTRL), 32'h2);
		repeat (3) @(posedge clock);
		chk("outPins paused", 32'h3ef, 32'(outPins));
		bus(1'b1, 32'(ADDR_CTRL), 32'h0);
		repeat (3) @(posedge clock);
		chk("outPins resumed", 32'h3eb, 32'(outPins));
		bus(1'b1, 32'(ADDR_CTRL), 32'h4);
		repeat (3) @(posedge clock);
		chk("running after abort", 32'h0, 32'(running));
	endtask
	task automatic t_in();
		do_reset();
		put(1, OP_INPUT, 0, 0, 8'd0, 17'h0, 2);
		put(2, OP_OUTPUT, 0, 0, 8'h0, 17'h0, 1);
		put(3, OP_INPUT, 0, 1, 8'd5, 17'h1, 1);
		put(4, OP_OUTPUT, 0, 0, 8'h0, 17'h0, 2);
		put(5, OP_INPUT, 0, 0, 8'd7, 17'h0, 3);
		put(6, OP_OUTPUT, 0, 0, 8'h0, 17'h0, 3);
		put(7, OP_HALT, 0, 0, 8'h0, 17'h0, 0);
		start();
		repeat (20) @(posedge clock);
		chk("stalled running", 32'h1, 32'(running));
		chk("stalled outPins", 32'h3ff, 32'(outPins));
		pressed <= 8'h2;
		run();
		chk("input branches", 32'h3fa, 32'(outPins));
	endtask
	task automatic t_math();
		do_reset();
		bus(1'b1, 32'(ADDR_DREG), 32'h0a00);
		bus(1'b1, 32'(ADDR_DREG) + 32'h8, 32'h0a00);
		put(1, OP_ARITH, 0, 0, AR_ADD, 17'd6, 0);
		put(2, OP_ARITH, 0, 0, AR_SUB, 17'd4, 0);
		put(3, OP_ARITH, 0, 0, AR_MUL, 17'd3, 0);
		put(4, OP_ARITH, 0, 0, AR_DIV, 17'd4, 0);
		put(5, OP_ARITH, 1, 0, AR_CPY, 17'd0, 1);
		put(6, OP_CMP, 0, 0, CMP_EQ, 17'd9, 1);
		put(7, OP_OUTPUT, 0, 0, 8'h0, 17'h0, 1);
		put(8, OP_CMP, 0, 0, CMP_GT, 17'd9, 0);
		put(9, OP_OUTPUT, 0, 0, 8'h0, 17'h0, 2);
		put(10, OP_CMP, 1, 0, CMP_LT, 17'd2, 0);
		put(11, OP_OUTPUT, 0, 0, 8'h0, 17'h0, 3);
		put(12, OP_HALT, 0, 0, 8'h0, 17'h0, 0);
		run();
		bus(1'b0, 32'(ADDR_DREG), 32'h0);
		chk("arith result", 32'h0900, rd);
		bus(1'b0, 32'(ADDR_DREG) + 32'h4, 32'h0);
		chk("copied register", 32'h0900, rd);
		chk("compare skips", 32'h3fd, 32'(outPins));
	endtask
	task automatic t_loop();
		do_reset();
		put(1, OP_ARITH, 0, 0, AR_ADD, 17'd1, 2);
		put(2, OP_LOOP, 0, 0, 8'h0, 17'd3, 1);
		put(3, OP_JUMP, 0, 0, 8'h0, 17'h0, 5);
		put(4, OP_ARITH, 0, 0, AR_ADD, 17'd100, 2);
		put(5, OP_HALT, 0, 0, 8'h0, 17'h0, 0);
		run();
		bus(1'b0, 32'(ADDR_DREG) + 32'h8, 32'h0);
		chk("loop passes", 32'h0400, rd);
	endtask
	task automatic t_delay();
		int n;
		do_reset();
		put(1, OP_DELAY, 0, 0, 8'h0, 17'h0, 3);
		put(2, OP_HALT, 0, 0, 8'h0, 17'h0, 0);
		bus(1'b1, 32'(ADDR_CTRL), 32'h1);
		n = 0;
		repeat (2) @(posedge clock);
		while (running === 1'b1 && n < 1000)
		begin
			@(posedge clock);
			n++;
		end
		chk("delay span", 32'h1, 32'(n >= 3 * MS && n <= 3 * MS + 8));
	endtask
	task automatic t_home();
		do_reset();
		bus(1'b1, 32'(ADDR_HOMEDIV), 32'h1);
		put(1, OP_HOME, 0, 0, 8'd1, 17'd11, 3);
		put(2, OP_HOME, 0, 0, 8'd0, 17'd10, 2);
		put(3, OP_HALT, 0, 0, 8'h0, 17'h0, 0);
		run();
		chk("z forward", 32'h1, 32'(port_u.netSteps[2] inside {[5:8]}));
		chk("y reverse", 32'h1, 32'(port_u.netSteps[1] inside {[-8:-5]}));
		bus(1'b0, 32'(ADDR_POS) + 32'h8, 32'h0);
		chk("z zeroed", 32'h0, rd);
		bus(1'b0, 32'(ADDR_POS) + 32'h4, 32'h0);
		chk("y zeroed", 32'h0, rd);
		// port 1 stays open, so homing x runs until the abort leaves it off zero
		put(1, OP_HOME, 0, 0, 8'd1, 17'd1, 1);
		put(2, OP_HALT, 0, 0, 8'h0, 17'h0, 0);
		start();
		repeat (20) @(posedge clock);
		bus(1'b1, 32'(ADDR_CTRL), 32'h4);
		bus(1'b0, 32'(ADDR_POS), 32'h0);
		chk("x forward", 32'h1, 32'(rd != 32'h0 && !rd[31]));
		put(1, OP_SETORG, 0, 0, 8'h0, 17'h0, 5);
		run();
		bus(1'b0, 32'(ADDR_POS), 32'h0);
		chk("x origin set", 32'h0, rd);
		put(1, OP_HOME, 0, 0, 8'd0, 17'd1, 1);
		start();
		repeat (20) @(posedge clock);
		bus(1'b1, 32'(ADDR_CTRL), 32'h4);
		bus(1'b0, 32'(ADDR_POS), 32'h0);
		chk("x reverse", 32'h1, 32'(rd[31]));
		put(1, OP_HOME, 0, 0, 8'd0, 17'd0, 1);
		run();
		bus(1'b0, 32'(ADDR_POS), 32'h0);
		chk("x back at zero", 32'h0, rd);
	endtask
	initial
	begin
		hsel = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		rst_b = 1'b0;
		pressed = 8'h0;
		failures = 0;
		check_count = 0;
		cycles = 0;
		t_out();
		t_in();
		t_math();
		t_loop();
		t_delay();
		t_home();
		results();
	end
endmodule // test_motion_program_sequencer
